/* hw/cdto_consts.svh */
// Constants for the CAN dominant timeout front end
`ifndef CDTO_CONSTS_SVH
`define CDTO_CONSTS_SVH
// Dominant timeout period, shortest figure, in microseconds
`define CDTO_PERIOD_US 1200
// Clock rate in MHz
`define CDTO_CLK_MHZ 25
// Cycles in the timeout period
`define CDTO_PERIOD_CYC (`CDTO_PERIOD_US * `CDTO_CLK_MHZ)
// Pin and reset levels
`define CDTO_RECESSIVE 1'h1
`define CDTO_DOMINANT 1'h0
`define CDTO_ACTIVE 1'h1
`define CDTO_INACTIVE 1'h0
`endif

/* hw/cdto_front.sv */
// CAN transceiver digital front end with dominant timeout
// Contract
// - Low transmit input with driver enabled drives the bus dominant.
// - Undriven bus stays recessive, reading as logic one.
// - Each transmit falling edge starts the dominant timeout timer.
// - Timer expiry without rising edge disables the bus driver.
// - Transmit input returning high clears timeout and re-enables driver.
// - During timeout the bus stays recessive, receive still follows bus.
// - Receive output low for dominant bus, high for recessive or open.
// - Passes traffic at rates up to 5 Mbps.
// - Undriven transmit input (tx_driven low) is forced recessive.
`timescale 1ns/1ns
`include "cdto_consts.svh"
module cdto_front
  import cdto_pkg::*;
#(
  parameter int PERIOD_CYC = `CDTO_PERIOD_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic tx_data,
  input  wire logic tx_driven,
  input  wire logic bus_dominant,
  input  wire logic bus_open,
  output logic      rx_data,
  output logic      bus_drive,
  output logic      dominant_timeout
);
  localparam int CW = $clog2(PERIOD_CYC + 1);

  logic        tx_s1_q;
  logic        tx_s2_q;
  logic        drv_s1_q;
  logic        drv_s2_q;
  logic        tx_prev_q;
  logic        dom_s1_q;
  logic        dom_s2_q;
  logic        opn_s1_q;
  logic        opn_s2_q;
  logic        tx_in;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  cdto_state_t state_q;
  cdto_state_t state_d;
  logic        rx_d;
  logic        drive_d;
  logic        tmo_d;

  assign tx_in = drv_s2_q ? tx_s2_q : `CDTO_RECESSIVE;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_s1_q   <= `CDTO_RECESSIVE;
      tx_s2_q   <= `CDTO_RECESSIVE;
      drv_s1_q  <= `CDTO_ACTIVE;
      drv_s2_q  <= `CDTO_ACTIVE;
      tx_prev_q <= `CDTO_RECESSIVE;
      dom_s1_q  <= `CDTO_INACTIVE;
      dom_s2_q  <= `CDTO_INACTIVE;
      opn_s1_q  <= `CDTO_ACTIVE;
      opn_s2_q  <= `CDTO_ACTIVE;
    end else begin
      tx_s1_q   <= tx_data;
      tx_s2_q   <= tx_s1_q;
      drv_s1_q  <= tx_driven;
      drv_s2_q  <= drv_s1_q;
      tx_prev_q <= tx_in;
      dom_s1_q  <= bus_dominant;
      dom_s2_q  <= dom_s1_q;
      opn_s1_q  <= bus_open;
      opn_s2_q  <= opn_s1_q;
    end
  end

  // Timer and timeout state
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      CDTO_ST_RUN: begin
        if (tx_prev_q && !tx_in) begin
          cnt_d = CW'(1);
        end else if (!tx_in) begin
          if (cnt_q < CW'(PERIOD_CYC)) begin
            cnt_d = cnt_q + CW'(1);
          end
        end else begin
          cnt_d = '0;
        end
        if (!tx_in && cnt_q >= CW'(PERIOD_CYC)) begin
          state_d = CDTO_ST_TMO;
        end
      end
      CDTO_ST_TMO: begin
        if (tx_in) begin
          state_d = CDTO_ST_RUN;
          cnt_d   = '0;
        end
      end
      default: begin
        state_d = CDTO_ST_RUN;
        cnt_d   = '0;
      end
    endcase
  end

  // Output values
  always_comb begin
    // drive only when low and not timed out
    drive_d = !tx_in && (state_d == CDTO_ST_RUN);
    // receive mirrors bus, open reads high
    rx_d    = !(dom_s2_q && !opn_s2_q);
    tmo_d   = (state_d == CDTO_ST_TMO);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q          <= CDTO_ST_RUN;
      cnt_q            <= '0;
      rx_data          <= `CDTO_RECESSIVE;
      bus_drive        <= `CDTO_INACTIVE;
      dominant_timeout <= `CDTO_INACTIVE;
    end else begin
      state_q          <= state_d;
      cnt_q            <= cnt_d;
      rx_data          <= rx_d;
      bus_drive        <= drive_d;
      dominant_timeout <= tmo_d;
    end
  end

  // Assertions
  property p_drive_low;
    @(posedge clk) disable iff (rst)
      (!tx_in && !dominant_timeout && cnt_q < CW'(PERIOD_CYC))
      |=> bus_drive;
  endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("driver not on for dominant input");

  property p_rec;
    @(posedge clk) disable iff (rst)
      tx_in |=> !bus_drive;
  endproperty
  a_rec: assert property (p_rec)
    else $error("driver on for recessive input");

  property p_start;
    @(posedge clk) disable iff (rst)
      (state_q == CDTO_ST_RUN && tx_prev_q && !tx_in) |=> cnt_q == CW'(1);
  endproperty
  a_start: assert property (p_start)
    else $error("timer did not start on falling edge");

  property p_expire;
    @(posedge clk) disable iff (rst)
      (state_q == CDTO_ST_RUN && !tx_in && cnt_q >= CW'(PERIOD_CYC))
      |=> dominant_timeout && !bus_drive;
  endproperty
  a_expire: assert property (p_expire)
    else $error("timeout did not disable driver");

  property p_clear;
    @(posedge clk) disable iff (rst)
      (dominant_timeout && tx_in) |=> !dominant_timeout;
  endproperty
  a_clear: assert property (p_clear)
    else $error("timeout not cleared by recessive input");

  property p_tmo_rec;
    @(posedge clk) disable iff (rst)
      dominant_timeout |-> !bus_drive;
  endproperty
  a_tmo_rec: assert property (p_tmo_rec)
    else $error("driver on during timeout");

  property p_rx;
    @(posedge clk) disable iff (rst)
      ##1 (rx_data == !($past(dom_s2_q) && !$past(opn_s2_q)));
  endproperty
  a_rx: assert property (p_rx)
    else $error("receive output does not follow bus");

  property p_rst;
    @(posedge clk)
      $fell(rst) |-> !dominant_timeout && cnt_q == '0;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset did not clear timeout");

  property p_status;
    @(posedge clk) disable iff (rst)
      dominant_timeout == $past(state_d == CDTO_ST_TMO);
  endproperty
  a_status: assert property (p_status)
    else $error("status does not track timeout state");

  property p_float;
    @(posedge clk) disable iff (rst)
      !drv_s2_q |=> !bus_drive;
  endproperty
  a_float: assert property (p_float)
    else $error("driver on for undriven transmit pin");

  property p_rate;
    @(posedge clk) disable iff (rst)
      (!dominant_timeout && tx_prev_q != tx_in)
      |=> bus_drive != $past(bus_drive);
  endproperty
  a_rate: assert property (p_rate)
    else $error("transmit edge not passed within one cycle");

  property p_open;
    @(posedge clk) disable iff (rst)
      opn_s2_q |=> rx_data;
  endproperty
  a_open: assert property (p_open)
    else $error("receive output low for open bus");
endmodule // cdto_front

/* hw/cdto_pkg.sv */
// Types for the CAN dominant timeout front end
package cdto_pkg;
  typedef enum logic [1:0] {
    CDTO_ST_RUN = 2'h1,
    CDTO_ST_TMO = 2'h2
  } cdto_state_t;
endpackage

/* test/cdto_host.sv */
// Host controller model for the transmit pin
`timescale 1ns/1ns
module cdto_host (
  input  wire logic clk,
  output logic      tx_data,
  output logic      tx_driven
);
  initial begin
    tx_data   = 1'h1;
    tx_driven = 1'h1;
  end
  task automatic send(input logic b, input int n);
    @(negedge clk);
    tx_driven = 1'h1;
    tx_data   = b;
    repeat (n - 1) @(negedge clk);
  endtask
  task automatic float_pin(input int n);
    @(negedge clk);
    tx_driven = 1'h0;
    tx_data   = ~tx_data;
    repeat (n - 1) @(negedge clk);
  endtask
endmodule // cdto_host

/* test/tb_cdto_front.sv */
// Bench for the dominant timeout front end
`timescale 1ns/1ns
module tb_cdto_front;
  localparam int P = 20;
  logic clk, rst, other_dom, bus_open, bus_dominant;
  logic tx_data, tx_driven, rx_data, bus_drive, dominant_timeout;
  int   n_errors, samples_checked, cyc;
  // Bus is dominant when any node drives
  assign bus_dominant = bus_drive | other_dom;
  cdto_host u_host (.clk(clk), .tx_data(tx_data), .tx_driven(tx_driven));
  cdto_front #(.PERIOD_CYC(P)) u_dut (
    .clk(clk), .rst(rst), .tx_data(tx_data), .tx_driven(tx_driven),
    .bus_dominant(bus_dominant), .bus_open(bus_open), .rx_data(rx_data),
    .bus_drive(bus_drive), .dominant_timeout(dominant_timeout));
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  task automatic check(input logic seen, input logic exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      n_errors++;
      complete_run;
    end
  end
  // Loop latency: 3 edges to the driver, 6 edges to the receive output
  task automatic t_basic;
    u_host.send(1'h0, 8);
    check(bus_drive, 1'h1);
    check(rx_data, 1'h0);
    u_host.send(1'h1, 8);
    check(bus_drive, 1'h0);
    check(rx_data, 1'h1);
  endtask
  // Timeout shows on the edge P + 3 after the low is applied
  task automatic t_timeout;
    u_host.send(1'h0, P + 3);
    check(dominant_timeout, 1'h0);
    check(bus_drive, 1'h1);
    @(negedge clk);
    check(dominant_timeout, 1'h1);
    check(bus_drive, 1'h0);
    repeat (3) @(negedge clk);
    check(rx_data, 1'h1);
    other_dom = 1'h1;
    repeat (3) @(negedge clk);
    check(rx_data, 1'h0);
    other_dom = 1'h0;
    u_host.send(1'h1, 5);
    check(dominant_timeout, 1'h0);
    u_host.send(1'h0, 5);
    check(bus_drive, 1'h1);
    u_host.send(1'h1, 5);
  endtask
  task automatic t_float;
    u_host.float_pin(6);
    check(bus_drive, 1'h0);
    u_host.send(1'h1, 2);
  endtask
  task automatic t_open;
    other_dom = 1'h1;
    bus_open  = 1'h1;
    repeat (5) @(negedge clk);
    check(rx_data, 1'h1);
    bus_open = 1'h0;
    repeat (5) @(negedge clk);
    check(rx_data, 1'h0);
    other_dom = 1'h0;
  endtask
  // Five-cycle bits; receive output still shows the previous bit
  task automatic t_rate;
    for (int i = 0; i < 6; i++) begin
      u_host.send(i[0], 5);
      check(bus_drive, ~i[0]);
      if (i > 0) begin
        check(rx_data, ~i[0]);
      end
    end
  endtask
  task automatic t_reset;
    u_host.send(1'h0, P + 4);
    check(dominant_timeout, 1'h1);
    rst = 1'h1;
    #5;
    check(dominant_timeout, 1'h0);
    check(bus_drive, 1'h0);
    @(negedge clk);
    rst = 1'h0;
    repeat (P + 1) @(negedge clk);
    check(dominant_timeout, 1'h0);
    repeat (3) @(negedge clk);
    check(dominant_timeout, 1'h1);
    u_host.send(1'h1, 5);
    check(dominant_timeout, 1'h0);
  endtask
  initial begin
    rst       = 1'h1;
    other_dom = 1'h0;
    bus_open  = 1'h0;
    repeat (4) @(negedge clk);
    rst = 1'h0;
    t_basic;
    t_timeout;
    t_float;
    t_open;
    t_rate;
    t_reset;
    complete_run;
  end
endmodule // tb_cdto_front
